// ==== logic/link_timing_params.svh ====
// Offsets, field positions, reset values and timing figures of the link timing registers
`ifndef LINK_TIMING_PARAMS_SVH
`define LINK_TIMING_PARAMS_SVH

`define CLK_PERIOD_NS        10
`define ADDR_CHIP_TIME       8'h23
`define ADDR_TIMING_TWO      8'h24
`define CHIP_TIME_RESET      8'h00
`define TIMING_TWO_RESET     8'h00
`define UNMAPPED_READ        8'h00
// timing_config_two field positions
`define T2_NIBBLE_SRC_BIT    7
`define T2_WINDOW_HI         6
`define T2_WINDOW_LO         4
`define T2_CAP_OFF_BIT       3
`define T2_RESERVED_BIT      2
`define T2_FRAG_SIZE_BIT     1
`define T2_DIAG_EN_BIT       0
`define T2_WRITABLE_MASK     8'hfb
// Chip and bit times in ns
`define PSI5_FAST_NS         5300
`define PSI5_SLOW_NS         8000
`define DSI3_FIXED_NS        5000
`define SLEW_OFF_LAST_CODE   4'h1
// Oscillator training error period
`define OSC_PERIOD_NS        4000000
`define OSC_MAX_PERIODS      7'h40
// Background diagnostic fragment sizes
`define FRAG_CMD_SMALL       3'h2
`define FRAG_RSP_SMALL       3'h3
`define FRAG_CMD_LARGE       3'h4
`define FRAG_RSP_LARGE       3'h6

`endif

// ==== logic/link_timing_pkg.sv ====
// Types shared by the link timing register block
`default_nettype none
package link_timing_pkg;
  typedef enum logic [2:0] {
    mode_dsi3      = 3'h0,
    mode_psi5      = 3'h1,
    mode_spi       = 3'h2,
    mode_i2c       = 3'h3,
    mode_psi5_prog = 3'h4
  } mode_type;

  typedef enum logic [1:0] {
    xfer_periodic   = 2'h0,
    xfer_command    = 2'h1,
    xfer_background = 2'h2
  } xfer_type;

  typedef enum logic [1:0] {
    osc_idle  = 2'b00,
    osc_count = 2'b01,
    osc_fault = 2'b11
  } osc_state_type;
endpackage
`default_nettype wire

// ==== logic/osc_watch_if.sv ====
// Link between the register block and the oscillator training watchdog
`default_nettype none
interface osc_watch_if;
  logic       busy;
  logic [2:0] window;
  logic       fault;
  modport watchdog (input busy, input window, output fault);
  modport owner    (output busy, output window, input fault);
endinterface
`default_nettype wire

// ==== logic/osc_train_watchdog.sv ====
// Counts 4 ms periods of oscillator training and raises the training fault
`default_nettype none
`include "link_timing_params.svh"
module osc_train_watchdog #(
  parameter int PERIOD_CYCLES = `OSC_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire logic      mclk,
  input  wire logic      rst_n,
  osc_watch_if.watchdog  watch
);
  // Refuse a zero period while elaborating, not at run time
  if (PERIOD_CYCLES < 1)
  begin : g_bad_period
    $error("PERIOD_CYCLES must be at least 1");
  end

  link_timing_pkg::osc_state_type state;
  link_timing_pkg::osc_state_type next_state;
  logic [31:0] tick;
  logic [31:0] next_tick;
  logic [6:0]  periods;
  logic [6:0]  next_periods;
  logic [6:0]  limit;
  logic        fault;
  logic        next_fault;

  ////////////////////////////////////////////////////////////////////////////
  // Code 000 means the longest window, so the table wraps to 64
  always_comb
  begin
    limit = (watch.window == 3'h0) ? `OSC_MAX_PERIODS : 7'(7'h1 << (watch.window - 3'h1));
  end

  // Training dropping out restarts the count and clears the fault
  always_comb
  begin
    next_state   = state;
    next_tick    = tick;
    next_periods = periods;
    next_fault   = fault;
    unique case (state)
      link_timing_pkg::osc_idle:
      begin
        next_tick    = 32'h0;
        next_periods = 7'h0;
        next_fault   = 1'b0;
        if (watch.busy)
          next_state = link_timing_pkg::osc_count;
      end
      link_timing_pkg::osc_count:
      begin
        if (!watch.busy)
          next_state = link_timing_pkg::osc_idle;
        else if (tick == 32'(PERIOD_CYCLES - 1))
        begin
          next_tick    = 32'h0;
          next_periods = periods + 7'h1;
          if (periods + 7'h1 >= limit)
          begin
            next_fault = 1'b1;
            next_state = link_timing_pkg::osc_fault;
          end
        end
        else
          next_tick = tick + 32'h1;
      end
      link_timing_pkg::osc_fault:
      begin
        if (!watch.busy)
          next_state = link_timing_pkg::osc_idle;
      end
      default:
        next_state = link_timing_pkg::osc_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state   <= link_timing_pkg::osc_idle;
      tick    <= 32'h0;
      periods <= 7'h0;
      fault   <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      tick    <= next_tick;
      periods <= next_periods;
      fault   <= next_fault;
    end
  end

  assign watch.fault = fault;
endmodule
`default_nettype wire

// ==== logic/link_timing_config_regs.sv ====
// Chip time and second timing configuration registers with the logic they steer
`default_nettype none
`include "link_timing_params.svh"

// What this block does
// - DSI3 periodic chip time and slew from code
// - DSI3 command and diagnostic use fixed 5 us
// - PSI5 bit time from code top bit
// - SPI and I2C store code, no effect
// - Second timing register readable and writable in every mode except plain PSI5
// - Register contents feed the array error check
// - Nibble source picks init phase 2 data
// - Training fault after selected 4 ms periods
// - Capacitor test skipped when disable set
// - Capacitor fault sets buffer undervoltage flag
// - Disabling capacitor test refused during undervoltage
// - Fragment size picks command bits, response chips
// - Diagnostic mode runs only when enabled
// - Inapplicable fields stored but have no effect
module link_timing_config_regs #(
  parameter int OSC_PERIOD_CYCLES = `OSC_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire link_timing_pkg::mode_type  link_mode,
  input  wire link_timing_pkg::xfer_type  xfer_kind,
  input  wire logic                       reg_wr_en,
  input  wire logic                       reg_rd_en,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  output logic [7:0]                      reg_rdata,
  output logic                            write_refused,
  input  wire logic [7:0]                 serial_number_byte_four,
  input  wire logic [7:0]                 user_byte_six,
  input  wire logic [7:0]                 user_byte_fourteen,
  output logic [3:0]                      init2_d19_nibble,
  output logic [3:0]                      init2_d20_nibble,
  output logic [9:0]                      link_period_cycles,
  output logic                            slew_enable,
  input  wire logic                       osc_train_busy,
  output logic                            oscillator_training_fault,
  input  wire logic                       cap_test_fault,
  output logic                            cap_test_run,
  output logic                            buffer_undervoltage_error,
  output logic                            diag_mode_active,
  output logic [2:0]                      diag_cmd_bits,
  output logic [2:0]                      diag_rsp_chips,
  output logic [15:0]                     rw_array_image,
  output logic                            rw_array_parity
);
  // Refuse a zero training period while elaborating
  if (OSC_PERIOD_CYCLES < 1)
  begin : g_bad_period
    $error("OSC_PERIOD_CYCLES must be at least 1");
  end

  localparam logic [9:0] PSI5_FAST_CYC  = 10'(`PSI5_FAST_NS / `CLK_PERIOD_NS);
  localparam logic [9:0] PSI5_SLOW_CYC  = 10'(`PSI5_SLOW_NS / `CLK_PERIOD_NS);
  localparam logic [9:0] DSI3_FIXED_CYC = 10'(`DSI3_FIXED_NS / `CLK_PERIOD_NS);

  logic [7:0] chip_time_reg;
  logic [7:0] timing_config_two;
  logic [7:0] next_chip_time_reg;
  logic [7:0] next_timing_config_two;
  logic [7:0] next_reg_rdata;
  logic       next_write_refused;
  logic       next_uv;
  logic [3:0] next_d19;
  logic [3:0] next_d20;
  logic [9:0] next_period;
  logic       next_slew;
  logic       next_cap_run;
  logic       next_diag_active;
  logic [2:0] next_cmd_bits;
  logic [2:0] next_rsp_chips;
  logic       is_dsi3;
  logic       is_psi5;
  logic [3:0] chip_time_code;

  osc_watch_if watch ();

  ////////////////////////////////////////////////////////////////////////////
  // DSI3 periodic chip time per code, in ns
  function automatic logic [9:0] dsi3_cycles(input logic [3:0] code);
    int ns;
    ns = 1000;
    unique case (code)
      4'h0: ns = 1000;
      4'h1: ns = 2000;
      4'h2: ns = 2500;
      4'h3: ns = 2600;
      4'h4: ns = 2600;
      4'h5: ns = 2700;
      4'h6: ns = 2800;
      4'h7: ns = 2900;
      4'h8: ns = 3000;
      4'h9: ns = 3100;
      4'ha: ns = 3200;
      4'hb: ns = 3300;
      4'hc: ns = 3500;
      4'hd: ns = 4000;
      4'he: ns = 4500;
      4'hf: ns = 5000;
    endcase
    return 10'(ns / `CLK_PERIOD_NS);
  endfunction

  assign chip_time_code = chip_time_reg[3:0];
  assign is_dsi3        = (link_mode == link_timing_pkg::mode_dsi3);
  assign is_psi5        = (link_mode == link_timing_pkg::mode_psi5) || (link_mode == link_timing_pkg::mode_psi5_prog);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; plain PSI5 runtime carries no register traffic
  always_comb
  begin
    next_chip_time_reg     = chip_time_reg;
    next_timing_config_two = timing_config_two;
    next_write_refused     = 1'b0;
    if (reg_wr_en && link_mode != link_timing_pkg::mode_psi5)
    begin
      if (reg_addr == `ADDR_CHIP_TIME)
        next_chip_time_reg = reg_wdata;
      else if (reg_addr == `ADDR_TIMING_TWO)
      begin
        // A registered undervoltage flag blocks turning the capacitor test off
        if (buffer_undervoltage_error && reg_wdata[`T2_CAP_OFF_BIT] && !timing_config_two[`T2_CAP_OFF_BIT])
          next_write_refused = 1'b1;
        else
          next_timing_config_two = reg_wdata & `T2_WRITABLE_MASK;
      end
    end
  end

  // Read port; unmapped addresses answer zero
  always_comb
  begin
    next_reg_rdata = reg_rdata;
    if (reg_rd_en && link_mode != link_timing_pkg::mode_psi5)
    begin
      if (reg_addr == `ADDR_CHIP_TIME)
        next_reg_rdata = chip_time_reg;
      else if (reg_addr == `ADDR_TIMING_TWO)
        next_reg_rdata = timing_config_two;
      else
        next_reg_rdata = `UNMAPPED_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link timing; SPI and I2C use the fixed 5 us DSI3 time
  always_comb
  begin
    next_period = dsi3_cycles(chip_time_code);
    next_slew   = (chip_time_code > `SLEW_OFF_LAST_CODE);
    if (is_psi5)
    begin
      next_period = chip_time_code[3] ? PSI5_SLOW_CYC : PSI5_FAST_CYC;
      next_slew   = 1'b1;
    end
    else if (is_dsi3 && xfer_kind != link_timing_pkg::xfer_periodic)
    begin
      next_period = DSI3_FIXED_CYC;
      next_slew   = 1'b1;
    end
    else if (!is_dsi3)
    begin
      next_period = DSI3_FIXED_CYC;
      next_slew   = 1'b1;
    end
  end

  // Init phase 2 nibbles only meaningful in PSI5
  always_comb
  begin
    next_d19 = 4'h0;
    next_d20 = 4'h0;
    if (is_psi5)
    begin
      if (timing_config_two[`T2_NIBBLE_SRC_BIT])
      begin
        next_d19 = user_byte_six[7:4];
        next_d20 = user_byte_fourteen[7:4];
      end
      else
      begin
        next_d19 = serial_number_byte_four[7:4];
        next_d20 = serial_number_byte_four[3:0];
      end
    end
  end

  // Capacitor test and diagnostic mode act in DSI3 only
  always_comb
  begin
    next_cap_run     = is_dsi3 && !timing_config_two[`T2_CAP_OFF_BIT];
    next_uv          = next_cap_run && cap_test_fault;
    next_diag_active = is_dsi3 && timing_config_two[`T2_DIAG_EN_BIT];
    next_cmd_bits    = timing_config_two[`T2_FRAG_SIZE_BIT] ? `FRAG_CMD_LARGE : `FRAG_CMD_SMALL;
    next_rsp_chips   = timing_config_two[`T2_FRAG_SIZE_BIT] ? `FRAG_RSP_LARGE : `FRAG_RSP_SMALL;
    if (!next_diag_active)
    begin
      next_cmd_bits  = 3'h0;
      next_rsp_chips = 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_time_reg             <= `CHIP_TIME_RESET;
      timing_config_two         <= `TIMING_TWO_RESET;
      reg_rdata                 <= 8'h00;
      write_refused             <= 1'b0;
      init2_d19_nibble          <= 4'h0;
      init2_d20_nibble          <= 4'h0;
      link_period_cycles        <= 10'h0;
      slew_enable               <= 1'b0;
      cap_test_run              <= 1'b0;
      buffer_undervoltage_error <= 1'b0;
      diag_mode_active          <= 1'b0;
      diag_cmd_bits             <= 3'h0;
      diag_rsp_chips            <= 3'h0;
      rw_array_image            <= 16'h0;
      rw_array_parity           <= 1'b0;
      oscillator_training_fault <= 1'b0;
    end
    else
    begin
      chip_time_reg             <= next_chip_time_reg;
      timing_config_two         <= next_timing_config_two;
      reg_rdata                 <= next_reg_rdata;
      write_refused             <= next_write_refused;
      init2_d19_nibble          <= next_d19;
      init2_d20_nibble          <= next_d20;
      link_period_cycles        <= next_period;
      slew_enable               <= next_slew;
      cap_test_run              <= next_cap_run;
      buffer_undervoltage_error <= next_uv; // Clears once the fault recovers
      diag_mode_active          <= next_diag_active;
      diag_cmd_bits             <= next_cmd_bits;
      diag_rsp_chips            <= next_rsp_chips;
      rw_array_image            <= {timing_config_two, chip_time_reg};
      rw_array_parity           <= ^{timing_config_two, chip_time_reg};
      oscillator_training_fault <= watch.fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Training watchdog runs in every mode since training is reachable on all links
  assign watch.busy   = osc_train_busy;
  assign watch.window = timing_config_two[`T2_WINDOW_HI:`T2_WINDOW_LO];

  osc_train_watchdog #(
    .PERIOD_CYCLES (OSC_PERIOD_CYCLES)
  ) u_watchdog (
    .mclk  (mclk),
    .rst_n (rst_n),
    .watch (watch.watchdog)
  );
endmodule
`default_nettype wire

// ==== tb/link_timing_config_regs_asserts.sv ====
// Port-level assertions for the link timing register block
`default_nettype none
module link_timing_config_regs_asserts (
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input wire link_timing_pkg::mode_type link_mode,
  input wire link_timing_pkg::xfer_type xfer_kind,
  input wire logic                      reg_wr_en,
  input wire logic [7:0]                reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic                      write_refused,
  input wire logic [9:0]                link_period_cycles,
  input wire logic                      slew_enable,
  input wire logic                      osc_train_busy,
  input wire logic                      oscillator_training_fault,
  input wire logic                      cap_test_fault,
  input wire logic                      cap_test_run,
  input wire logic                      buffer_undervoltage_error,
  input wire logic                      diag_mode_active,
  input wire logic [2:0]                diag_cmd_bits,
  input wire logic [15:0]               rw_array_image
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Outputs come from last cycle's mode and registers; the image lags the registers by the same cycle
  // The first edge after any reset release still shows reset values, so each check on a past mode or fault input needs a live previous cycle
  AST_DSI3_SLEW:
    assert property ($past(rst_n) && $past(link_mode) == link_timing_pkg::mode_dsi3 && $past(xfer_kind) == 2'h0
      |-> slew_enable == (rw_array_image[3:0] > 4'h1)) else $error("periodic slew wrong");
  AST_DSI3_FIXED:
    assert property ($past(rst_n) && $past(link_mode) == link_timing_pkg::mode_dsi3 && $past(xfer_kind) != 2'h0
      |-> link_period_cycles == 10'h1f4 && slew_enable) else $error("fixed chip time wrong");
  AST_PSI5_BIT:
    assert property ($past(rst_n) && $past(link_mode) inside {3'h1, 3'h4}
      |-> link_period_cycles == (rw_array_image[3] ? 10'h320 : 10'h212) && slew_enable) else $error("bit time wrong");
  AST_SERIAL_IGNORES:
    assert property ($past(rst_n) && $past(link_mode) inside {3'h2, 3'h3}
      |-> link_period_cycles == 10'h1f4) else $error("serial mode time wrong");
  AST_RESERVED_ZERO:
    assert property (rw_array_image[10] == 1'b0) else $error("reserved bit set");
  AST_CAP_RUN:
    assert property ($past(rst_n)
      |-> cap_test_run == ($past(link_mode) == link_timing_pkg::mode_dsi3 && !rw_array_image[11]))
      else $error("cap test run wrong");
  AST_UV_FLAG:
    assert property ($past(rst_n) |-> buffer_undervoltage_error == (cap_test_run && $past(cap_test_fault)))
      else $error("uv flag wrong");
  AST_REFUSE:
    assert property (reg_wr_en && !$past(reg_wr_en) && reg_addr == 8'h24 && reg_wdata[3] && !rw_array_image[11]
      && buffer_undervoltage_error && link_mode != 3'h1 |=> write_refused) else $error("write not refused");
  AST_DIAG_EN:
    assert property ($past(rst_n)
      |-> diag_mode_active == ($past(link_mode) == link_timing_pkg::mode_dsi3 && rw_array_image[8]))
      else $error("diag enable wrong");
  AST_FRAG:
    assert property (diag_mode_active |-> diag_cmd_bits == (rw_array_image[9] ? 3'h4 : 3'h2))
      else $error("fragment size wrong");
  AST_FAULT_DROP:
    assert property (!osc_train_busy [*5] |-> !oscillator_training_fault) else $error("fault stuck");
  // Main scenarios reached
  cover property (write_refused);
  cover property (diag_mode_active && rw_array_image[9]);
  cover property (oscillator_training_fault);
endmodule
bind link_timing_config_regs link_timing_config_regs_asserts i_chk (.*);
`default_nettype wire

// ==== tb/reg_host_model.sv ====
// Host master issuing one-cycle register strobes
`default_nettype none
module reg_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       write_refused,
  output var logic        reg_wr_en,
  output var logic        reg_rd_en,
  output var logic [7:0]  reg_addr,
  output var logic [7:0]  reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic refused;
  // Idle bus from time zero
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    refused   = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // No ready exists, so the edge after raising the strobe takes it; refusal shows just after
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1;
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = v;
    @(posedge mclk);
    #1;
    reg_wr_en = 1'b0;
    refused   = write_refused;
  endtask
  // Read data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    #1;
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(posedge mclk);
    #1;
    reg_rd_en = 1'b0;
    v         = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the link timing register block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OSC_P = 4; // Short training period keeps the 64-period case quick
  typedef struct packed {logic [3:0] code; logic [9:0] period;} row_type;
  logic mclk, rst_n, reg_wr_en, reg_rd_en, write_refused, slew_enable, osc_train_busy;
  logic oscillator_training_fault, cap_test_fault, cap_test_run, buffer_undervoltage_error;
  logic diag_mode_active, rw_array_parity;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, serial_number_byte_four, user_byte_six, user_byte_fourteen, d, e;
  logic [3:0] init2_d19_nibble, init2_d20_nibble;
  logic [2:0] diag_cmd_bits, diag_rsp_chips;
  logic [9:0] link_period_cycles;
  logic [15:0] rw_array_image;
  link_timing_pkg::mode_type link_mode;
  link_timing_pkg::xfer_type xfer_kind;
  int bad_count, num_checks, n;
  row_type rows [16] = '{'{4'h0, 10'h064}, '{4'h1, 10'h0c8}, '{4'h2, 10'h0fa}, '{4'h3, 10'h104},
    '{4'h4, 10'h104}, '{4'h5, 10'h10e}, '{4'h6, 10'h118}, '{4'h7, 10'h122}, '{4'h8, 10'h12c},
    '{4'h9, 10'h136}, '{4'ha, 10'h140}, '{4'hb, 10'h14a}, '{4'hc, 10'h15e}, '{4'hd, 10'h190},
    '{4'he, 10'h1c2}, '{4'hf, 10'h1f4}};
  link_timing_config_regs #(.OSC_PERIOD_CYCLES(OSC_P)) i_dut (.*);
  reg_host_model i_host (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Hang guard, well past the 1300 or so cycles the tests need
  initial
  begin
    #200us;
    bad_count++;
    summarize();
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Registered outputs need one edge for the register and one for the derived value
  task automatic set_mode(input link_timing_pkg::mode_type m, input link_timing_pkg::xfer_type x);
    @(posedge mclk);
    #1;
    link_mode = m;
    xfer_kind = x;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    link_mode = link_timing_pkg::mode_dsi3;
    xfer_kind = link_timing_pkg::xfer_periodic;
    {osc_train_busy, cap_test_fault} = 2'b00;
    {serial_number_byte_four, user_byte_six, user_byte_fourteen} = 24'h5ac396;
    repeat (20) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      i_host.wr(8'h23, {4'h0, rows[i].code});
      set_mode(link_timing_pkg::mode_dsi3, link_timing_pkg::xfer_periodic);
      chk("period", rows[i].period, link_period_cycles);
      chk("slew", rows[i].code > 4'h1, slew_enable);
      set_mode(link_timing_pkg::mode_dsi3, link_timing_pkg::xfer_background);
      chk("bg period", 10'h1f4, link_period_cycles);
      set_mode(link_timing_pkg::mode_dsi3, link_timing_pkg::xfer_command);
      chk("cmd period", 10'h1f4, link_period_cycles);
      chk("cmd slew", 1'b1, slew_enable);
      set_mode(link_timing_pkg::mode_psi5_prog, link_timing_pkg::xfer_command);
      chk("psi5 period", rows[i].code[3] ? 10'h320 : 10'h212, link_period_cycles);
      set_mode(link_timing_pkg::mode_i2c, link_timing_pkg::xfer_periodic);
      chk("i2c period", 10'h1f4, link_period_cycles);
      i_host.rd(8'h23, d);
      chk("chip time", rows[i].code, d);
    end
    // Second reset in mid-run, then reset values and an unmapped read
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    i_host.rd(8'h24, d);
    chk("t2 reset", 8'h00, d);
    i_host.rd(8'h23, d);
    chk("ct reset", 8'h00, d);
    i_host.rd(8'h40, d);
    chk("unmapped", 8'h00, d);
    for (int m = 4; m >= 0; m--)
    begin
      set_mode(link_timing_pkg::mode_type'(m), link_timing_pkg::xfer_periodic);
      i_host.wr(8'h24, 8'hff - m);
      i_host.rd(8'h24, d);
      // Plain PSI5 drops both strobes, so the value written and read in SPI stays
      e = (m == 1) ? 8'hf9 : 8'((8'hff - m) & 8'hfb);
      chk("t2 rw", e, d);
      chk("image", {e, 8'h00}, rw_array_image);
      chk("parity", ^e, rw_array_parity);
    end
    // Nibble source in programming mode, silent in DSI3
    for (int s = 0; s < 2; s++)
    begin
      set_mode(link_timing_pkg::mode_psi5_prog, link_timing_pkg::xfer_periodic);
      i_host.wr(8'h24, {s[0], 7'h00});
      set_mode(link_timing_pkg::mode_psi5_prog, link_timing_pkg::xfer_periodic);
      chk("d19", s ? 4'hc : 4'h5, init2_d19_nibble);
      chk("d20", s ? 4'h9 : 4'ha, init2_d20_nibble);
      set_mode(link_timing_pkg::mode_dsi3, link_timing_pkg::xfer_periodic);
      chk("d19 dsi3", 4'h0, init2_d19_nibble);
    end
    // Diagnostic enable and both fragment sizes, then SPI keeps it off
    for (int v = 0; v < 4; v++)
    begin
      i_host.wr(8'h24, v[7:0]);
      set_mode(link_timing_pkg::mode_dsi3, link_timing_pkg::xfer_periodic);
      chk("diag on", v[0], diag_mode_active);
      chk("cmd bits", v[0] ? (v[1] ? 3'h4 : 3'h2) : 3'h0, diag_cmd_bits);
      chk("rsp chips", v[0] ? (v[1] ? 3'h6 : 3'h3) : 3'h0, diag_rsp_chips);
      set_mode(link_timing_pkg::mode_spi, link_timing_pkg::xfer_periodic);
      chk("diag spi", 1'b0, diag_mode_active);
      chk("cap spi", 1'b0, cap_test_run);
    end
    // Capacitor fault blocks disabling the test until it recovers
    i_host.wr(8'h24, 8'h00);
    set_mode(link_timing_pkg::mode_dsi3, link_timing_pkg::xfer_periodic);
    chk("cap run", 1'b1, cap_test_run);
    cap_test_fault = 1'b1;
    set_mode(link_timing_pkg::mode_dsi3, link_timing_pkg::xfer_periodic);
    chk("uv set", 1'b1, buffer_undervoltage_error);
    i_host.wr(8'h24, 8'h08);
    chk("refused", 1'b1, i_host.refused);
    i_host.rd(8'h24, d);
    chk("t2 kept", 8'h00, d);
    cap_test_fault = 1'b0;
    set_mode(link_timing_pkg::mode_dsi3, link_timing_pkg::xfer_periodic);
    chk("uv clear", 1'b0, buffer_undervoltage_error);
    i_host.wr(8'h24, 8'h08);
    chk("accepted", 1'b0, i_host.refused);
    set_mode(link_timing_pkg::mode_dsi3, link_timing_pkg::xfer_periodic);
    chk("cap off", 1'b0, cap_test_run);
    // Every training window code, checked just before and just after its span
    for (int c = 0; c < 8; c++)
    begin
      n = (c == 0) ? 64 : 1 << (c - 1);
      i_host.wr(8'h24, {1'b0, c[2:0], 4'h0});
      osc_train_busy = 1'b1;
      // One edge to start counting, n periods, then one register stage to the pin
      repeat (n * OSC_P + 1) @(posedge mclk);
      #1;
      chk("fault early", 1'b0, oscillator_training_fault);
      repeat (1) @(posedge mclk);
      #1;
      chk("fault due", 1'b1, oscillator_training_fault);
      osc_train_busy = 1'b0;
      repeat (6) @(posedge mclk);
      #1;
    end
    summarize();
  end
endmodule
`default_nettype wire
